// [rtl/e1_alarm_pkg.sv]
// constants for the receive alarm and timer status monitor
// assumes a 200 MHz system clock and framer strobes on that clock
// Summary of operation
// - bit 7 shows last submultiframe 1 CRC
// - bit 6 shows last submultiframe 2 CRC
// - remote failure after five bad seconds
// - loss of signal after 192 zeros
// - loss ends on dense 192 window
// - bit 3 follows channel 16 all ones
// - bit 2 follows selected all-ones criterion
// - bit 1 follows remote alarm bit
// - bit 0 remote alarm plus CRC errors
// - timer bit 7 toggles every half second
// - timer bit 6 toggles every second
// - bit 5 toggles on 400 ms expiry
// - bit 3 toggles each millisecond, resynced
// - keep-alive after 100 ms all ones
// - sync loss persist set after 100 ms
// - sync gain persist set after 10 ms
// - frame alignment input high means lost
package e1_alarm_pkg;
    localparam logic [4:0] ALARM_STATUS_ADDR = 5'h11; // alarm word
    localparam logic [4:0] TIMER_STATUS_ADDR = 5'h12; // timer word
    localparam int unsigned CLK_HZ          = 200000000;
    localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
    localparam int unsigned KEEP_ALIVE_MS   = 100;
    localparam int unsigned LOSS_PERSIST_MS = 100;
    localparam int unsigned GAIN_PERSIST_MS = 10;
    localparam int unsigned SEARCH_MS       = 400;
    localparam int unsigned HALF_SEC_MS     = 500;
    localparam int unsigned LOS_WINDOW_BITS = 192;
    localparam int unsigned LOS_MIN_ONES    = 24;   // 12.5 percent of 192
    localparam int unsigned EBIT_LIMIT      = 989;
    localparam int unsigned FAIL_SECONDS    = 5;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
endpackage

// [rtl/ms_persist.sv]
// persistence counter in milliseconds
// assumes ms_tick is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
module ms_persist
    import e1_alarm_pkg::*;
#(
    parameter int unsigned LIMIT_MS = 100
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic cond,     // condition being timed
    input  wire logic ms_tick,  // one millisecond strobe
    output logic      expired   // cond held long enough
);
    initial begin
        if (LIMIT_MS < 1 || LIMIT_MS > 65535) $error("bad LIMIT_MS");
    end
    logic [15:0] count_q; // elapsed milliseconds
    // count while held, restart when dropped
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 16'h0000;
        end else if (!cond) begin
            count_q <= 16'h0000;
        end else if (ms_tick && count_q != LIMIT_MS[15:0]) begin
            count_q <= count_q + 16'h0001;
        end
    end
    // level, drops at once with cond
    assign expired = cond && (count_q == LIMIT_MS[15:0]);
endmodule

// [rtl/los_detect.sv]
// loss of signal detector on received bit slots
// assumes bit_stb marks one received bit period, pulse_in its value
`timescale 1ns/1ps
module los_detect
    import e1_alarm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic bit_stb,   // one per bit period
    input  wire logic pulse_in,  // pulse seen in this slot
    output logic      los        // loss of signal level
);
    logic [7:0] zero_run_q; // consecutive empty slots
    logic [7:0] win_pos_q;  // slots in open window
    logic [7:0] win_ones_q; // pulses in open window
    logic       win_open_q; // recovery window running
    logic       los_q;
    // zero run and window tracking
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            zero_run_q <= 8'h00;
            win_pos_q  <= 8'h00;
            win_ones_q <= 8'h00;
            win_open_q <= 1'b0;
            los_q      <= 1'b0;
        end else if (bit_stb) begin
            zero_run_q <= pulse_in ? 8'h00 : zero_run_q + 8'h01;
            if (!los_q && !pulse_in && zero_run_q == 8'(LOS_WINDOW_BITS - 1)) begin
                los_q <= 1'b1;
            end
            if (los_q) begin
                if (!win_open_q) begin
                    if (pulse_in) begin
                        win_open_q <= 1'b1;
                        win_pos_q  <= 8'h01;
                        win_ones_q <= 8'h01;
                    end
                end else if (win_pos_q == 8'(LOS_WINDOW_BITS - 1)) begin
                    win_open_q <= 1'b0;
                    if (win_ones_q + {7'h00, pulse_in} >= 8'(LOS_MIN_ONES)) begin
                        los_q <= 1'b0;
                    end
                end else begin
                    win_pos_q  <= win_pos_q + 8'h01;
                    win_ones_q <= win_ones_q + {7'h00, pulse_in};
                end
            end else begin
                win_open_q <= 1'b0;
            end
        end
    end
    assign los = los_q;
endmodule

// [rtl/e1_alarm_timer_status.sv]
// receive alarm and timer status words for the host
// assumes framer, crc checker and decoder strobes on sys_clk
`timescale 1ns/1ps
module e1_alarm_timer_status
    import e1_alarm_pkg::*;
#(
    parameter int unsigned MS_COUNT = MS_CYCLES // cycles per millisecond
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       smf1_done,          // submultiframe 1 checked
    input  wire logic       smf2_done,          // submultiframe 2 checked
    input  wire logic       smf_crc_bad,        // crc result of that check
    input  wire logic       ebit_error,         // one E-bit error strobe
    input  wire logic       frame_lost,         // 1 lost, 0 aligned
    input  wire logic       bit_stb,            // received bit period
    input  wire logic       pulse_in,           // pulse in that period
    input  wire logic       frame_stb,          // frame boundary
    input  wire logic       nfas_frame,         // frame lacks alignment word
    input  wire logic       ch16_all_ones,      // channel 16 all ones
    input  wire logic       ais_strict,         // all ones, strict criterion
    input  wire logic       ais_loose,          // all ones, loose criterion
    input  wire logic       alarm_criterion_select,
    input  wire logic       remote_alarm_bit,   // received A bit
    input  wire logic       mf_stb,             // multiframe boundary
    input  wire logic       crc_continuous,     // continuous crc errors
    input  wire logic       search_expired,     // 400 ms search timer ended
    input  wire logic       crc_sync_acquired,  // crc multiframe aligned
    input  wire logic       crc_sync_stb,       // receive crc sync pulse
    input  wire logic       non_normal_frames,  // abnormal frames seen
    input  wire logic       rd_en,              // host read strobe
    input  wire logic       wr_en,              // host write strobe
    input  wire logic [4:0] addr,               // host address
    output logic      [7:0] rd_data             // read data
);
    initial begin
        if (MS_COUNT < 2 || MS_COUNT > 65535) $error("bad MS_COUNT");
    end

    logic [7:0]  alarm_q;      // alarm word
    logic [7:0]  timer_q;      // timer word
    logic [7:0]  rd_data_q;
    logic [15:0] ms_div_q;     // cycle divider
    logic [9:0]  half_div_q;   // ms divider to half second
    logic        ms_tick;      // one-cycle ms strobe
    logic        half_tick;    // one-cycle half second strobe
    logic [10:0] ebit_cnt_q;   // errors this second
    logic [2:0]  bad_secs_q;   // run of bad seconds
    logic        sec_clean_q;  // no alarm, aligned this second
    logic        phase_q;      // second phase of half ticks
    logic        los;
    logic        keep_alive;
    logic        loss_persist;
    logic        gain_persist;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_div_q   <= 16'h0000;
            half_div_q <= 10'h000;
        end else if (ms_div_q == 16'(MS_COUNT - 1)) begin
            ms_div_q <= 16'h0000;
            half_div_q <= (half_div_q == 10'(HALF_SEC_MS - 1)) ? 10'h000
                                                               : half_div_q + 10'h001;
        end else begin
            ms_div_q <= ms_div_q + 16'h0001;
        end
    end
    assign ms_tick   = (ms_div_q == 16'(MS_COUNT - 1));
    assign half_tick = ms_tick && (half_div_q == 10'(HALF_SEC_MS - 1));

    // loss of signal on the bit stream
    los_detect u_los (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .bit_stb  (bit_stb),
        .pulse_in (pulse_in),
        .los      (los)
    );

    ms_persist #(.LIMIT_MS(KEEP_ALIVE_MS)) u_keep (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .cond    (alarm_q[2]),
        .ms_tick (ms_tick),
        .expired (keep_alive)
    );

    ms_persist #(.LIMIT_MS(LOSS_PERSIST_MS)) u_loss (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .cond    (frame_lost),
        .ms_tick (ms_tick),
        .expired (loss_persist)
    );

    ms_persist #(.LIMIT_MS(GAIN_PERSIST_MS)) u_gain (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .cond    (!frame_lost),
        .ms_tick (ms_tick),
        .expired (gain_persist)
    );

    // per-second E-bit accounting for the remote failure flag
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ebit_cnt_q  <= 11'h000;
            bad_secs_q  <= 3'h0;
            sec_clean_q <= 1'b1;
            phase_q     <= 1'b0;
        end else if (half_tick) begin
            phase_q <= !phase_q;
            if (phase_q) begin
                // five bad seconds in a row
                if (sec_clean_q && ebit_cnt_q > 11'(EBIT_LIMIT)) begin
                    bad_secs_q <= (bad_secs_q == 3'(FAIL_SECONDS)) ? bad_secs_q
                                                                   : bad_secs_q + 3'h1;
                end else begin
                    bad_secs_q <= 3'h0;
                end
                ebit_cnt_q  <= {10'h000, ebit_error};
                sec_clean_q <= 1'b1;
            end else begin
                if (ebit_error && ebit_cnt_q != 11'h7ff) begin
                    ebit_cnt_q <= ebit_cnt_q + 11'h001;
                end
            end
        end else begin
            if (ebit_error && ebit_cnt_q != 11'h7ff) begin
                ebit_cnt_q <= ebit_cnt_q + 11'h001;
            end
            if (frame_lost || remote_alarm_bit) begin
                sec_clean_q <= 1'b0;
            end
        end
    end

    // alarm word bits
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_q <= STATUS_RESET;
        end else begin
            if (smf1_done) alarm_q[7] <= smf_crc_bad;
            if (smf2_done) alarm_q[6] <= smf_crc_bad;
            alarm_q[5] <= (bad_secs_q == 3'(FAIL_SECONDS));
            alarm_q[4] <= los;
            if (frame_stb) alarm_q[3] <= ch16_all_ones;
            alarm_q[2] <= alarm_criterion_select ? ais_loose : ais_strict;
            if (frame_stb && nfas_frame) alarm_q[1] <= remote_alarm_bit;
            if (mf_stb) alarm_q[0] <= alarm_q[1] && crc_continuous;
        end
    end

    // timer word bits
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_q <= STATUS_RESET;
        end else begin
            if (half_tick) timer_q[7] <= !timer_q[7];
            if (half_tick && phase_q) timer_q[6] <= !timer_q[6];
            if (search_expired) timer_q[5] <= !timer_q[5];
            timer_q[4] <= 1'b0;
            // ms toggle, crc sync when aligned
            if (crc_sync_acquired ? crc_sync_stb : ms_tick) timer_q[3] <= !timer_q[3];
            timer_q[2] <= keep_alive;
            // set on loss, clear on gain
            if (gain_persist) begin
                timer_q[1] <= 1'b0;
            end else if (loss_persist) begin
                timer_q[1] <= 1'b1;
            end
            if (non_normal_frames) begin
                timer_q[0] <= 1'b0;
            end else if (gain_persist) begin
                timer_q[0] <= 1'b1;
            end
        end
    end

    // host read port; writes are ignored
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                ALARM_STATUS_ADDR: rd_data_q <= alarm_q;
                TIMER_STATUS_ADDR: rd_data_q <= timer_q;
                default:           rd_data_q <= 8'h00;
            endcase
        end
    end
    assign rd_data = rd_data_q;

    // write strobe only exists for bus symmetry
    logic wr_seen;
    assign wr_seen = wr_en;
endmodule

// [testbench/line_model.sv]
// line decoder model feeding bit slots to the loss-of-signal logic
// assumes the bench clock; silent stops every pulse on the line
`timescale 1ns/1ps
module line_model (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic silent,   // line carries no pulses
    output logic      bit_stb,  // one per bit period
    output logic      pulse_in  // slot value, noise between slots
);
    logic [4:0] slot_q;  // low two bits: clock in slot, upper: slot mod 8

    // one slot every four clocks
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) slot_q <= 5'h00;
        else slot_q <= slot_q + 5'h01;

    assign bit_stb = slot_q[1:0] == 2'h3;
    // a pulse on every eighth slot sits exactly on the 12.5 percent edge;
    // between slots the level toggles so no stale value can be relied on
    assign pulse_in = bit_stb ? (!silent && slot_q[4:2] == 3'h0) : slot_q[0];
endmodule

// [testbench/e1_status_checker_asserts.sv]
// read-port checker for the alarm and timer status words
// assumes it is bound to e1_alarm_timer_status
`timescale 1ns/1ps
module e1_status_checker
    import e1_alarm_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       smf1_done,
    input wire logic       smf2_done,
    input wire logic       smf_crc_bad,
    input wire logic       ais_strict,
    input wire logic       ais_loose,
    input wire logic       alarm_criterion_select,
    input wire logic       mf_stb,
    input wire logic       crc_continuous,
    input wire logic       rd_en,
    input wire logic [4:0] addr,
    input wire logic [7:0] rd_data
);
    logic       sel_ais;  // all-ones input picked by the select
    logic       rd_al;    // alarm word read
    logic       rd_tm;    // timer word read
    logic [1:0] up_q;     // edges since reset, so $past never sees reset
    assign sel_ais = alarm_criterion_select ? ais_loose : ais_strict;
    assign rd_al   = rd_en && addr == ALARM_STATUS_ADDR;
    assign rd_tm   = rd_en && addr == TIMER_STATUS_ADDR;

    // saturating count of edges after release
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_unmapped_read_zero: assert property (rd_en && !rd_al && !rd_tm
        |=> rd_data == 8'h00) else $error("unmapped read not zero");
    a_read_data_holds: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data moved without a read");
    a_timer_spare_zero: assert property (rd_tm |=> !rd_data[4])
        else $error("timer bit 4 not zero");
    a_smf1_crc_bit: assert property (smf1_done ##1 !smf1_done ##1 (rd_al && !smf1_done)
        |=> rd_data[7] == $past(smf_crc_bad, 3)) else $error("bit 7 wrong");
    a_smf2_crc_bit: assert property (smf2_done ##1 !smf2_done ##1 (rd_al && !smf2_done)
        |=> rd_data[6] == $past(smf_crc_bad, 3)) else $error("bit 6 wrong");
    a_ais_follows_select: assert property (rd_al && up_q == 2'h3 && $stable(sel_ais)
        && $past(sel_ais) == $past(sel_ais, 2) && $past(sel_ais, 2) == $past(sel_ais, 3)
        |=> rd_data[2] == $past(sel_ais)) else $error("bit 2 not the chosen criterion");
    a_combined_needs_crc: assert property ((mf_stb && !crc_continuous) ##1 !mf_stb
        ##1 (rd_al && !mf_stb) |=> !rd_data[0]) else $error("bit 0 set without crc");
    a_keep_alive_drops: assert property (rd_tm && up_q == 2'h3 && !sel_ais
        && !$past(sel_ais) && !$past(sel_ais, 2) && !$past(sel_ais, 3)
        |=> !rd_data[2]) else $error("keep-alive high without all ones");

    c_smf1_read: cover property (smf1_done ##1 !smf1_done ##1 rd_al);
    c_timer_read: cover property (rd_tm);
    c_combined: cover property (mf_stb && crc_continuous);
endmodule

bind e1_alarm_timer_status e1_status_checker i_status_checker (
    .sys_clk(sys_clk), .reset_n(reset_n), .smf1_done(smf1_done), .smf2_done(smf2_done),
    .smf_crc_bad(smf_crc_bad), .ais_strict(ais_strict), .ais_loose(ais_loose),
    .alarm_criterion_select(alarm_criterion_select), .mf_stb(mf_stb),
    .crc_continuous(crc_continuous), .rd_en(rd_en), .addr(addr), .rd_data(rd_data)
);

// [testbench/testbench.sv]
// self-checking bench for the alarm and timer status monitor
// assumes the package, line model and checker are compiled first
`timescale 1ns/1ps
module testbench;
    import e1_alarm_pkg::*;
    localparam int unsigned MS = 10;  // short millisecond keeps the run small
    logic sys_clk, reset_n, smf1_done, smf2_done, smf_crc_bad, ebit_error, frame_lost;
    logic frame_stb, nfas_frame, ch16_all_ones, ais_strict, ais_loose, sel, ra, mf_stb;
    logic crc_continuous, search_expired, non_normal_frames, rd_en, wr_en, silent, ebit_on;
    logic crc_acq, crc_stb;         // crc multiframe aligned level and sync pulse
    logic       bit_stb, pulse_in;  // from the line model
    logic [4:0] addr;               // host address
    logic [7:0] rd_data, a, b, c;   // read data and saved words
    logic [31:0] s;                 // random state
    logic       ra_exp;             // expected remote alarm flag
    int         n_errors, cmp_count, cyc, t0, k;

    line_model i_line_model (.sys_clk(sys_clk), .reset_n(reset_n), .silent(silent),
        .bit_stb(bit_stb), .pulse_in(pulse_in));
    e1_alarm_timer_status #(.MS_COUNT(MS)) i_e1_alarm_timer_status (
        .sys_clk(sys_clk), .reset_n(reset_n), .smf1_done(smf1_done), .smf2_done(smf2_done),
        .smf_crc_bad(smf_crc_bad), .ebit_error(ebit_error), .frame_lost(frame_lost),
        .bit_stb(bit_stb), .pulse_in(pulse_in), .frame_stb(frame_stb),
        .nfas_frame(nfas_frame), .ch16_all_ones(ch16_all_ones), .ais_strict(ais_strict),
        .ais_loose(ais_loose), .alarm_criterion_select(sel), .remote_alarm_bit(ra),
        .mf_stb(mf_stb), .crc_continuous(crc_continuous), .search_expired(search_expired),
        .crc_sync_acquired(crc_acq), .crc_sync_stb(crc_stb),
        .non_normal_frames(non_normal_frames),
        .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .rd_data(rd_data));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // error strobes every other cycle, well above the per-second limit
    always @(posedge sys_clk) ebit_error <= #1 ebit_on & ~ebit_error;
    always @(posedge sys_clk) cyc <= cyc + 1;

    function automatic logic [31:0] lf(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic exp_ais(input logic sl, st, lo);
        return sl ? lo : st;  // select high picks the loose criterion
    endfunction
    task automatic step(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // read ends one idle cycle later so rd_en is never driven twice at once
    task automatic rd(input logic [4:0] ad, output logic [7:0] d);
        rd_en = 1'b1;
        addr  = ad;
        step();
        rd_en = 1'b0;
        d     = rd_data;
        step();
    endtask
    task automatic chk(input logic [7:0] got, exp, m);
        cmp_count++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h mask %h", $time, got, exp, m);
        end
    endtask
    task automatic rc(input logic [4:0] ad, input logic [7:0] exp, m);
        logic [7:0] d;
        rd(ad, d);
        chk(d, exp, m);
    endtask
    // one-cycle strobe followed by a quiet cycle
    task automatic pls(input int p);
        case (p)
            0: smf1_done = 1'b1;
            1: smf2_done = 1'b1;
            2: frame_stb = 1'b1;
            3: mf_stb = 1'b1;
            4: search_expired = 1'b1;
            default: crc_stb = 1'b1;
        endcase
        step();
        {smf1_done, smf2_done, frame_stb, mf_stb, search_expired, crc_stb} = 6'h00;
        step();
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        {smf1_done, smf2_done, smf_crc_bad, frame_lost, frame_stb, nfas_frame} = 6'h00;
        {ch16_all_ones, ais_strict, ais_loose, sel, ra, mf_stb, crc_continuous} = 7'h00;
        {search_expired, non_normal_frames, rd_en, wr_en, silent, ebit_on, crc_acq, crc_stb} = 8'h00;
        addr = 5'h00; s = 32'hb35f; ra_exp = 1'b0; n_errors = 0; cmp_count = 0; cyc = 0;
        reset_n = 1'b0;
        step(12);
        reset_n = 1'b1;
        rc(ALARM_STATUS_ADDR, 8'h00, 8'hff);
        for (int i = 0; i < 32; i++)
            if (5'(i) != ALARM_STATUS_ADDR && 5'(i) != TIMER_STATUS_ADDR) rc(5'(i), 8'h00, 8'hff);
        {wr_en, addr} = {1'b1, ALARM_STATUS_ADDR};
        step();
        wr_en = 1'b0;
        rc(ALARM_STATUS_ADDR, 8'h00, 8'hff);
        for (int i = 0; i < 16; i++) begin
            s = lf(s);
            {smf_crc_bad, ch16_all_ones, nfas_frame, ra} = s[3:0];
            pls(int'(s[4]));
            rc(ALARM_STATUS_ADDR, {8{smf_crc_bad}}, s[4] ? 8'h40 : 8'h80);
            ra_exp = nfas_frame ? ra : ra_exp;
            pls(2);
            rc(ALARM_STATUS_ADDR, {4'h0, ch16_all_ones, 1'b0, ra_exp, 1'b0}, 8'h0a);
            {sel, ais_strict, ais_loose} = s[7:5];
            step(3);
            rc(ALARM_STATUS_ADDR, {8{exp_ais(sel, ais_strict, ais_loose)}}, 8'h04);
        end
        {ra, nfas_frame, crc_continuous, ais_strict, ais_loose} = 5'b11100;
        pls(2);
        pls(3);
        rc(ALARM_STATUS_ADDR, 8'h03, 8'h03);
        crc_continuous = 1'b0;
        pls(3);
        rc(ALARM_STATUS_ADDR, 8'h00, 8'h01);
        rd(TIMER_STATUS_ADDR, a);
        pls(4);
        rc(TIMER_STATUS_ADDR, ~a, 8'h20);
        // once crc aligned, only the sync pulse may move the ms bit
        crc_acq = 1'b1;
        rd(TIMER_STATUS_ADDR, a);
        step(25);
        rc(TIMER_STATUS_ADDR, a, 8'h08);
        pls(5);
        rc(TIMER_STATUS_ADDR, ~a, 8'h08);
        crc_acq = 1'b0;
        non_normal_frames = 1'b1;
        step(3);
        rc(TIMER_STATUS_ADDR, 8'h00, 8'h01);
        {non_normal_frames, frame_lost} = 2'b01;
        step(90 * MS);
        rc(TIMER_STATUS_ADDR, 8'h00, 8'h02);
        step(20 * MS);
        rc(TIMER_STATUS_ADDR, 8'h02, 8'h02);
        frame_lost = 1'b0;
        step(15 * MS);
        rc(TIMER_STATUS_ADDR, 8'h01, 8'h03);
        // clean seconds start here: errors on, no alarm, aligned
        {ebit_on, ra} = 2'b10;
        t0 = cyc;
        rd(TIMER_STATUS_ADDR, a);
        k = 0;
        do begin
            rd(TIMER_STATUS_ADDR, b);
            k++;
        end while (b[7] === a[7] && k < 3000);
        step(250 * MS + 3);
        rd(TIMER_STATUS_ADDR, a);
        step(500 * MS - 2);
        rd(TIMER_STATUS_ADDR, b);
        step(500 * MS - 2);
        rd(TIMER_STATUS_ADDR, c);
        chk({b[7], c[7], c[6], b[3]}, {~a[7], ~b[7], ~a[6], a[3]}, 8'h0f);
        chk({7'h00, (a[6] != b[6]) != (b[6] != c[6])}, 8'h01, 8'h01);
        // select left random by the loop; force the strict criterion
        {sel, ais_strict} = 2'b01;
        step(90 * MS);
        rc(TIMER_STATUS_ADDR, 8'h00, 8'h04);
        step(20 * MS);
        rc(TIMER_STATUS_ADDR, 8'h04, 8'h04);
        ais_strict = 1'b0;
        step(3);
        rc(TIMER_STATUS_ADDR, 8'h00, 8'h04);
        silent = 1'b1;
        step(600);
        rc(ALARM_STATUS_ADDR, 8'h00, 8'h10);
        step(200);
        rc(ALARM_STATUS_ADDR, 8'h10, 8'h10);
        silent = 1'b0;
        step(960);
        rc(ALARM_STATUS_ADDR, 8'h00, 8'h10);
        while (cyc - t0 < 4000 * MS) step();
        rc(ALARM_STATUS_ADDR, 8'h00, 8'h20);
        while (cyc - t0 < 6050 * MS) step();
        rc(ALARM_STATUS_ADDR, 8'h20, 8'h20);
        finish_test();
    end

    // hang guard: the tests need about 62000 cycles
    initial begin
        step(90000);
        n_errors++;
        finish_test();
    end
endmodule
